/* File: rtl/crs_pkg.sv */
// constants and types for the reset, self-test and sleep oversampling control register
package crs_pkg;
  // ----------------------------------------------------------------
  // register map and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_TWO_ADDR  = 8'h2b;
  localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
  localparam int         SELF_TEST_BIT  = 7;
  localparam int         RST_BIT        = 6;
  localparam int         SPARE_BIT      = 5;
  localparam int         SMODS_HI       = 4;
  localparam int         SMODS_LO       = 3;
  localparam int         WAKE_HI        = 2;
  localparam int         AXIS_W         = 14;
  localparam int         AXIS_N         = 3;
  localparam int         CNT_W          = 24;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint     CLK_HZ         = 25000000;
  localparam longint     HOST_GUARD_US  = 1000;
  localparam longint     BOOT_CYCLES_DEF = (HOST_GUARD_US * CLK_HZ) / 1000000;
  // sleep wake rates in millihertz, period rounded down
  localparam longint     SLEEP_MHZ_0    = 50000;
  localparam longint     SLEEP_MHZ_1    = 12500;
  localparam longint     SLEEP_MHZ_2    = 6250;
  localparam longint     SLEEP_MHZ_3    = 1560;
  localparam longint     SLEEP_DIV_0    = (CLK_HZ * 1000) / SLEEP_MHZ_0;
  localparam longint     SLEEP_DIV_1    = (CLK_HZ * 1000) / SLEEP_MHZ_1;
  localparam longint     SLEEP_DIV_2    = (CLK_HZ * 1000) / SLEEP_MHZ_2;
  localparam longint     SLEEP_DIV_3    = (CLK_HZ * 1000) / SLEEP_MHZ_3;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OSR_NORMAL  = 2'h0,
    OSR_LNLP    = 2'h1,
    OSR_HIRES   = 2'h2,
    OSR_LOWPWR  = 2'h3
  } crs_osr_t;

  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'h1,
    SEQ_DRAIN = 3'h2,
    SEQ_BOOT  = 3'h4
  } crs_seq_t;
endpackage : crs_pkg

/* File: rtl/crs_ctrl_two.sv */
// second control register: self-test, software/pin reset sequencing, sleep oversampling
//
// Functional notes
// - bit 7 enables the accelerometer self-test function.
// - self-test shifts every axis output level by a fixed amount.
// - writing 1 to bit 6 starts a software reset.
// - reset request accepted in standby and in active mode.
// - boot returns all functional block registers to defaults.
// - from active, force standby first, reboot once standby reached or a reset pin pulse arrives.
// - from standby, reboot starts at once.
// - high pulse on reset pin starts the same reset sequence.
// - any reset also resets the serial interface logic.
// - software reset bit self-clears when boot finishes.
// - bits 4 to 3 pick the sleep oversampling mode.
// - encoding: 00 normal, 01 low-noise low-power, 10 high-res, 11 low-power.
// - standby/active bit is forced to standby after any reset.
// - sleep data rate sets the sleep auto-wake sample frequency.
`timescale 1ns/100ps
module crs_ctrl_two
  import crs_pkg::*;
#(
  parameter longint             BOOT_CYCLES = BOOT_CYCLES_DEF,
  parameter longint             SLEEP_DIV0  = SLEEP_DIV_0,
  parameter longint             SLEEP_DIV1  = SLEEP_DIV_1,
  parameter longint             SLEEP_DIV2  = SLEEP_DIV_2,
  parameter longint             SLEEP_DIV3  = SLEEP_DIV_3,
  parameter logic [AXIS_W-1:0]  SELF_TEST_SHIFT = 14'h0100
) (
  input  wire logic                           core_clk,
  input  wire logic                           rst_n,
  input  wire logic [7:0]                     reg_addr,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  input  wire logic [7:0]                     reg_wdata,
  output logic      [7:0]                     reg_rdata,
  input  wire logic                           rst_pin,
  input  wire logic                           active_mode,
  input  wire logic                           sleep_mode,
  input  wire logic [1:0]                     aslp_rate,
  input  wire logic [AXIS_N-1:0][AXIS_W-1:0]  axis_raw,
  output logic      [AXIS_N-1:0][AXIS_W-1:0]  axis_out,
  output logic                                self_test_enable,
  output crs_osr_t                            sleep_osr_mode,
  output logic      [WAKE_HI:0]               wake_ctrl,
  output logic                                force_standby,
  output logic                                block_reset,
  output logic                                serial_reset,
  output logic                                sleep_tick
);

  // ----------------------------------------------------------------
  // constants derived from parameters
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] BOOT_LAST = CNT_W'(BOOT_CYCLES - 1);
  localparam logic [CNT_W-1:0] DIV0_LAST = CNT_W'(SLEEP_DIV0 - 1);
  localparam logic [CNT_W-1:0] DIV1_LAST = CNT_W'(SLEEP_DIV1 - 1);
  localparam logic [CNT_W-1:0] DIV2_LAST = CNT_W'(SLEEP_DIV2 - 1);
  localparam logic [CNT_W-1:0] DIV3_LAST = CNT_W'(SLEEP_DIV3 - 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]       control_two;
  logic [CNT_W-1:0] boot_cnt;
  logic [CNT_W-1:0] sleep_cnt;
  logic             pin_s1;
  logic             pin_s2;
  logic             pin_s3;
  crs_seq_t         state;
  crs_seq_t         next_state;

  function automatic logic [CNT_W-1:0] rate_last(input logic [1:0] rate);
    case (rate)
      2'h0:    rate_last = DIV0_LAST;
      2'h1:    rate_last = DIV1_LAST;
      2'h2:    rate_last = DIV2_LAST;
      default: rate_last = DIV3_LAST;
    endcase
  endfunction : rate_last

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic addr_hit = reg_addr == CTRL_TWO_ADDR;
  // writes during the sequence are dropped so a 0 cannot cancel a pending reset
  wire logic wr_hit   = reg_wr && addr_hit && state == SEQ_IDLE;
  wire logic sw_req   = wr_hit && reg_wdata[RST_BIT];
  wire logic hw_req   = pin_s2 && !pin_s3;
  wire logic boot_end = state == SEQ_BOOT && boot_cnt == BOOT_LAST;
  wire logic sleep_on = sleep_mode && state == SEQ_IDLE;
  wire logic [CNT_W-1:0] sleep_last = rate_last(aslp_rate);

  always_comb begin
    next_state = state;
    case (state)
      SEQ_IDLE: begin
        if (sw_req || hw_req) begin
          next_state = active_mode ? SEQ_DRAIN : SEQ_BOOT;
        end
      end
      SEQ_DRAIN: begin
        if (hw_req || !active_mode) begin
          next_state = SEQ_BOOT;
        end
      end
      SEQ_BOOT: begin
        if (hw_req) begin
          next_state = SEQ_BOOT;
        end else if (boot_end) begin
          next_state = SEQ_IDLE;
        end
      end
      default: next_state = SEQ_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // reset pin synchroniser; edge detect reads stages 2 and 3 only
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
    end else begin
      pin_s1 <= rst_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state    <= SEQ_IDLE;
      boot_cnt <= '0;
    end else begin
      state    <= next_state;
      // a fresh pin pulse restarts the boot window
      if (state != SEQ_BOOT || hw_req) begin
        boot_cnt <= '0;
      end else begin
        boot_cnt <= boot_cnt + CNT_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      control_two <= CTRL_TWO_RESET;
    end else if (boot_end && !hw_req) begin
      control_two <= CTRL_TWO_RESET;
    end else if (wr_hit) begin
      control_two <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= (reg_rd && addr_hit) ? control_two : 8'h00;
    end
  end

  assign self_test_enable = control_two[SELF_TEST_BIT];
  assign sleep_osr_mode   = crs_osr_t'(control_two[SMODS_HI:SMODS_LO]);
  assign wake_ctrl        = control_two[WAKE_HI:0];

  // ----------------------------------------------------------------
  // sequence outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      force_standby <= 1'b1;
      block_reset   <= 1'b1;
      serial_reset  <= 1'b1;
    end else begin
      force_standby <= next_state != SEQ_IDLE;
      block_reset   <= next_state == SEQ_BOOT;
      serial_reset  <= next_state == SEQ_BOOT;
    end
  end

  // ----------------------------------------------------------------
  // self-test shift, one adder per axis
  // ----------------------------------------------------------------
  generate
    for (genvar ax = 0; ax < AXIS_N; ax++) begin : g_axis
      wire logic [AXIS_W-1:0] shift = control_two[SELF_TEST_BIT] ? SELF_TEST_SHIFT : '0;
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          axis_out[ax] <= '0;
        end else begin
          axis_out[ax] <= axis_raw[ax] + shift;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // sleep auto-wake sample tick
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sleep_cnt  <= '0;
      sleep_tick <= 1'b0;
    end else if (!sleep_on) begin
      sleep_cnt  <= '0;
      sleep_tick <= 1'b0;
    end else if (sleep_cnt >= sleep_last) begin
      sleep_cnt  <= '0;
      sleep_tick <= 1'b1;
    end else begin
      sleep_cnt  <= sleep_cnt + CNT_W'(1);
      sleep_tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_selftest_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_hit |=> self_test_enable == $past(reg_wdata[SELF_TEST_BIT]))
    else $error("self-test enable does not follow write");

  a_axis_shift: assert property (@(posedge core_clk) disable iff (!rst_n)
    self_test_enable |=> axis_out[0] == AXIS_W'($past(axis_raw[0]) + SELF_TEST_SHIFT)
      && axis_out[1] == AXIS_W'($past(axis_raw[1]) + SELF_TEST_SHIFT)
      && axis_out[2] == AXIS_W'($past(axis_raw[2]) + SELF_TEST_SHIFT))
    else $error("axis output not shifted under self-test");

  a_rst_bit_pending: assert property (@(posedge core_clk) disable iff (!rst_n)
    control_two[RST_BIT] |-> state != SEQ_IDLE)
    else $error("reset bit set while sequencer idle");

  a_active_drain: assert property (@(posedge core_clk) disable iff (!rst_n)
    (sw_req && !hw_req && active_mode) |=> state == SEQ_DRAIN && force_standby && !block_reset)
    else $error("active reset did not drain to standby first");

  a_drain_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == SEQ_DRAIN && active_mode && !hw_req) |=> state == SEQ_DRAIN)
    else $error("reboot began before standby reached");

  a_standby_boot: assert property (@(posedge core_clk) disable iff (!rst_n)
    (sw_req && !active_mode) |=> state == SEQ_BOOT ##1 block_reset)
    else $error("standby reset did not boot at once");

  a_pin_boot: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(pin_s2) && state != SEQ_DRAIN && !active_mode |=> state == SEQ_BOOT)
    else $error("reset pin pulse ignored");

  a_serial_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == SEQ_BOOT |-> serial_reset && block_reset && force_standby)
    else $error("serial logic not held in reset during boot");

  a_rst_selfclear: assert property (@(posedge core_clk) disable iff (!rst_n)
    (boot_end && !hw_req) |=> control_two == CTRL_TWO_RESET && state == SEQ_IDLE && !serial_reset)
    else $error("reset bit not cleared at end of boot");

  a_zero_write_noop: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_hit && !reg_wdata[RST_BIT] && !hw_req) |=> state == SEQ_IDLE && !control_two[RST_BIT])
    else $error("writing zero to reset bit had an effect");

  a_osr_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_hit |=> sleep_osr_mode == $past(reg_wdata[SMODS_HI:SMODS_LO]))
    else $error("sleep oversampling mode does not follow write");

  a_axis_plain: assert property (@(posedge core_clk) disable iff (!rst_n)
    !self_test_enable |=> axis_out[1] == $past(axis_raw[1]))
    else $error("axis output shifted with self-test off");

  a_boot_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == SEQ_BOOT && !hw_req && boot_cnt != BOOT_LAST) |=> state == SEQ_BOOT && block_reset)
    else $error("boot window cut short");

  a_sleep_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
    !sleep_on |=> !sleep_tick)
    else $error("sleep tick outside idle sleep");

  a_read_back: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_rd && addr_hit) |=> reg_rdata == $past(control_two))
    else $error("read data differs from register");

  a_spare_store: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_hit |=> control_two[SPARE_BIT] == $past(reg_wdata[SPARE_BIT]))
    else $error("spare bit does not store written value");

  a_standby_forced: assert property (@(posedge core_clk) disable iff (!rst_n)
    state != SEQ_IDLE |-> force_standby)
    else $error("standby not forced during reset sequence");

  a_drain_no_boot: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == SEQ_DRAIN |-> !block_reset && !serial_reset)
    else $error("reboot outputs raised before standby");

endmodule : crs_ctrl_two

/* File: verification/crs_host_model.sv */
// host side model: one-cycle register strobes, reset pulses, quiet time after a reset
`timescale 1ns/100ps
module crs_host_model #(
  parameter int GUARD = 40
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        cmd_go,
  input  wire logic [1:0]  cmd_kind,
  input  wire logic [7:0]  cmd_addr,
  input  wire logic [7:0]  cmd_data,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [7:0]  reg_addr,
  output logic      [7:0]  reg_wdata,
  output logic             rst_pin,
  output logic             busy
);
  int   quiet;
  logic take;
  logic sets_rst;
  assign take     = cmd_go && !busy;
  assign sets_rst = (cmd_kind == 2'h2) || (cmd_kind == 2'h0 && cmd_addr == 8'h2b && cmd_data[6]);
  // no strobe at all while the device reboots
  assign busy     = (quiet != 0) || reg_wr || reg_rd || rst_pin;
  always_ff @(posedge core_clk) begin
    reg_wr    <= take && cmd_kind == 2'h0;
    reg_rd    <= take && cmd_kind == 2'h1;
    rst_pin   <= take && cmd_kind == 2'h2;
    // released bus lines toggle so a stale value never looks valid
    reg_addr  <= !rst_n ? 8'h00 : take ? cmd_addr : ~reg_addr;
    reg_wdata <= !rst_n ? 8'h00 : take ? cmd_data : ~reg_wdata;
    if (!rst_n) quiet <= 0;
    else if (take && sets_rst) quiet <= GUARD;
    else if (quiet != 0) quiet <= quiet - 1;
  end
endmodule : crs_host_model

/* File: verification/tb_crs_ctrl_two.sv */
// self-checking bench for the second control register
`timescale 1ns/100ps
module tb_crs_ctrl_two;
  import crs_pkg::*;
  localparam logic [13:0] SHIFT   = 14'h0100;
  localparam int          DIVS[4] = '{5, 8, 11, 14};
  logic                            core_clk    = 1'b0;
  logic                            rst_n       = 1'b0;
  logic                            cmd_go      = 1'b0;
  logic [1:0]                      cmd_kind    = 2'h0;
  logic [7:0]                      cmd_addr    = 8'h00;
  logic [7:0]                      cmd_data    = 8'h00;
  logic                            active_mode = 1'b0;
  logic                            sleep_mode  = 1'b0;
  logic [1:0]                      aslp_rate   = 2'h0;
  logic [AXIS_N-1:0][AXIS_W-1:0]   axis_raw    = '0;
  logic [AXIS_N-1:0][AXIS_W-1:0]   axis_out;
  logic                            reg_wr, reg_rd, rst_pin, busy;
  logic [7:0]                      reg_addr, reg_wdata, reg_rdata, v;
  logic                            self_test_enable, force_standby, block_reset, serial_reset, sleep_tick;
  crs_osr_t                        sleep_osr_mode;
  logic [WAKE_HI:0]                wake_ctrl;
  logic [15:0]                     lfsr        = 16'h33ea;
  int                              err_count   = 0;
  int                              tests_run   = 0;
  int                              cycles      = 0;
  int                              n;

  crs_host_model u_host (.core_clk(core_clk), .rst_n(rst_n), .cmd_go(cmd_go), .cmd_kind(cmd_kind),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .rst_pin(rst_pin), .busy(busy));
  // short counts keep the run small
  // self-test shift left at its default, SHIFT mirrors it
  crs_ctrl_two #(.BOOT_CYCLES(20), .SLEEP_DIV0(5), .SLEEP_DIV1(8), .SLEEP_DIV2(11), .SLEEP_DIV3(14))
    u_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rst_pin(rst_pin),
    .active_mode(active_mode), .sleep_mode(sleep_mode), .aslp_rate(aslp_rate), .axis_raw(axis_raw),
    .axis_out(axis_out), .self_test_enable(self_test_enable), .sleep_osr_mode(sleep_osr_mode),
    .wake_ctrl(wake_ctrl), .force_standby(force_standby), .block_reset(block_reset),
    .serial_reset(serial_reset), .sleep_tick(sleep_tick));

  initial forever #20 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic results();
    if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      results();
    end
  end

  task automatic chk(input logic [41:0] got, input logic [41:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : step

  function automatic logic [41:0] exp_axis(input logic [41:0] raw, input logic on);
    logic [41:0] r;
    for (int i = 0; i < 3; i++) r[i*14 +: 14] = raw[i*14 +: 14] + (on ? SHIFT : 14'h0000);
    return r;
  endfunction : exp_axis

  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic host(input logic [1:0] k, input logic [7:0] a, input logic [7:0] d);
    int w;
    w = 0;
    while (busy && w < 100) begin
      tick(1);
      w++;
    end
    cmd_kind = k;
    cmd_addr = a;
    cmd_data = d;
    cmd_go   = 1'b1;
    tick(1);
    cmd_go   = 1'b0;
  endtask : host

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host(2'h1, a, 8'h00);
    tick(1);
    chk(reg_rdata, exp, "read data");
  endtask : rd

  task automatic wait_tick();
    n = 0;
    do begin
      tick(1);
      n++;
    end while (!sleep_tick && n < 60);
  endtask : wait_tick

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    tick(8);
    rst_n = 1'b1;
    tick(1);
    chk(force_standby, 1'b0, "idle after reset");
    rd(8'h2b, 8'h00);
    rd(8'h2c, 8'h00);
    for (int i = 0; i < 8; i++) begin
      lfsr     = step(lfsr);
      v        = {lfsr[7], 1'b0, lfsr[5], i[1:0], lfsr[2:0]};
      axis_raw = {lfsr[13:0], ~lfsr[13:0], lfsr[15:2]};
      host(2'h0, 8'h2b, v);
      tick(1);
      chk(self_test_enable, v[7], "self test");
      chk(sleep_osr_mode, v[4:3], "sleep osr");
      chk(wake_ctrl, v[2:0], "low bits");
      chk(force_standby, 1'b0, "zero reset bit stays idle");
      tick(1);
      chk(axis_out, exp_axis(axis_raw, v[7]), "axis");
      rd(8'h2b, v);
    end
    host(2'h0, 8'h2b, 8'hc0);
    tick(1);
    chk(block_reset, 1'b1, "boot from standby");
    chk(serial_reset, 1'b1, "serial reset");
    chk(force_standby, 1'b1, "standby forced");
    rd(8'h2b, 8'h00);
    active_mode = 1'b1;
    host(2'h0, 8'h2b, 8'h40);
    tick(3);
    chk(force_standby, 1'b1, "drain");
    chk(block_reset, 1'b0, "no boot while active");
    active_mode = 1'b0;
    tick(3);
    chk(block_reset, 1'b1, "boot after standby");
    rd(8'h2b, 8'h00);
    host(2'h0, 8'h2b, 8'h98);
    tick(1);
    chk(sleep_osr_mode, OSR_LOWPWR, "low power code");
    host(2'h2, 8'h00, 8'h00);
    tick(5);
    chk(block_reset, 1'b1, "pin boot");
    chk(serial_reset, 1'b1, "pin serial reset");
    rd(8'h2b, 8'h00);
    // second reset in mid-run, register loaded first
    host(2'h0, 8'h2b, 8'ha8);
    tick(1);
    rst_n = 1'b0;
    tick(3);
    chk(serial_reset, 1'b1, "serial reset held");
    rst_n = 1'b1;
    tick(1);
    chk(force_standby, 1'b0, "idle after second reset");
    chk(self_test_enable, 1'b0, "self test cleared");
    rd(8'h2b, 8'h00);
    sleep_mode = 1'b1;
    for (int r = 0; r < 4; r++) begin
      aslp_rate = r[1:0];
      wait_tick();
      wait_tick();
      chk(n, DIVS[r], "sleep period");
    end
    results();
  end
endmodule : tb_crs_ctrl_two
